// *** dual_comparator_control.v ***
/*
 * Digital control around two analog comparators: control register, output
 * inversion, input and output multiplexer steering, change flag with
 * mismatch capture, interrupt request and port F digital view, all reached
 * over an AXI4-Lite slave.
 * Assumes the analog comparators deliver raw outputs synchronous to aclk's
 * domain only after two flops, and that the analog switches obey the select
 * outputs. Port F is eight bits; pins configured analog read as zero.
 */
// Operation
// - Raw comparator output is high when noninverting input exceeds inverting input.
// - Per-comparator invert bits (5 and 4) complement reported and routed outputs.
// - Control bits 7 and 6 show post-inversion outputs, read only.
// - Mode field bits 2..0 selects one of eight input and output configurations.
// - In mode 110 input switch selects pins five/three or six/four.
// - Mode 110 connects internal reference to both noninverting inputs.
// - Routing modes pass raw unsynchronized outputs to port pins one and two.
// - Port direction bits still gate the drivers of routed pins.
// - Change flag sets on any output change of either comparator.
// - Flag clears only by writing zero; writing one sets it.
// - Request needs change enable, peripheral enable and global enable.
// - Mismatch keeps setting flag; control register access recaptures outputs.
// - Change coinciding with control register read may miss setting flag.
// - Active comparators run in sleep and wake device; register kept.
// - Mode 111 powers both comparators off.
// - Reset clears control register, mode 000, pins analog, comparators off.
// - Port data reads zero for pins configured analog.
// - Flag, enable and priority occupy bit 6 of their registers.
`timescale 1ns/1ns
`default_nettype none
`include "cmp_consts.vh"

module dual_comparator_control #(
    parameter ADDR_WIDTH = 6
) (
    input wire aclk,
    input wire aresetn,
    input wire [ADDR_WIDTH-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [ADDR_WIDTH-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire cmp_one_raw,
    input wire cmp_two_raw,
    input wire [7:0] port_f_pin_in,
    input wire sleeping,
    output reg [7:0] port_f_pin_out,
    output reg [7:0] port_f_pin_oe,
    output reg [7:0] port_f_analog,
    output reg cmp_one_power,
    output reg cmp_two_power,
    output reg [2:0] cmp_mode_field,
    output reg internal_ref_to_noninverting,
    output reg cmp_one_inv_sel_line_five,
    output reg cmp_two_inv_sel_line_three,
    output reg cmp_irq,
    output reg cmp_irq_high_priority,
    output reg wake_request
);

    // Control register fields; only bits 5..0 are storage, 7..6 are live results.
    localparam [7:0] CTL_RESET = `RST_COMPARATOR_CONTROL;
    reg cmp_two_invert;
    reg cmp_one_invert;
    reg inverting_input_switch;
    reg [2:0] mode;
    reg [7:0] interrupt_control;
    reg [7:0] peripheral_irq_flags_two;
    reg [7:0] peripheral_irq_enables_two;
    reg [7:0] peripheral_irq_priorities_two;
    reg [7:0] port_f_direction;
    reg [7:0] port_f_latch;

    // Synchronisers, captured copy and result bits.
    reg [1:0] one_sync;
    reg [1:0] two_sync;
    reg [1:0] captured;
    wire cmp_one_result;
    wire cmp_two_result;

    // Bus holding registers.
    reg aw_held;
    reg w_held;
    reg [ADDR_WIDTH-1:0] aw_addr;
    reg [31:0] w_data;
    reg [3:0] w_strb;

    // Mode decode: which modes route outputs to pins one and two.
    function routes_outputs;
        input [2:0] m;
        begin
            routes_outputs = (m == 3'h3) || (m == 3'h5);
        end
    endfunction

    // Modes 000 and 111 both hold the comparators off: 000 is the reset state,
    // 111 is the low-power choice before sleep.
    function powers_on;
        input [2:0] m;
        begin
            powers_on = (m != `MODE_RESET) && (m != `MODE_OFF);
        end
    endfunction

    // Mode decode: internal reference on both noninverting inputs, and the
    // only mode in which the input switch bit has any effect.
    function uses_internal_ref;
        input [2:0] m;
        begin
            uses_internal_ref = (m == `MODE_INTERNAL_REF);
        end
    endfunction

    // Mode decode: pins of port F (lines 1..6) left analog by a mode.
    function [7:0] analog_pins;
        input [2:0] m;
        begin
            if (m == `MODE_OFF) begin
                analog_pins = 8'h00;
            end else if (routes_outputs(m)) begin
                // Routing modes leave pins one and two digital, so that the
                // direction bits can still enable their drivers.
                analog_pins = 8'h78;
            end else if (m == 3'h4) begin
                analog_pins = 8'h78;
            end else begin
                analog_pins = 8'h7e;
            end
        end
    endfunction

    function [3:0] word_index;
        input [ADDR_WIDTH-1:0] a;
        begin
            word_index = a[5:2];
        end
    endfunction

    // Post-inversion results, derived from synchronised raw outputs.
    assign cmp_one_result = one_sync[1] ^ cmp_one_invert;
    assign cmp_two_result = two_sync[1] ^ cmp_two_invert;
    wire [1:0] results = {cmp_two_result, cmp_one_result};

    // Routed pins bypass the synchronisers, so they may glitch while an
    // analog input crosses over; the status bits never do.
    wire routed_one = cmp_one_raw ^ cmp_one_invert;
    wire routed_two = cmp_two_raw ^ cmp_two_invert;

    wire [7:0] comparator_control = {cmp_two_result, cmp_one_result, cmp_two_invert,
        cmp_one_invert, inverting_input_switch, mode};

    // A write commits once both halves are held and the last response is gone.
    wire do_write = aw_held && w_held && !s_axi_bvalid;
    wire do_read = s_axi_arvalid && s_axi_arready;
    wire [3:0] wr_idx = word_index(aw_addr);
    wire [3:0] rd_idx = word_index(s_axi_araddr);
    wire wr_lane0 = do_write && w_strb[0];
    wire ctl_access = (wr_lane0 && wr_idx == `OFS_COMPARATOR_CONTROL) ||
        (do_read && rd_idx == `OFS_COMPARATOR_CONTROL);
    wire mismatch = (captured != results);
    // A change landing on the access cycle is absorbed into the new capture,
    // so that one change may not set the flag.
    wire flag_event = mismatch && !ctl_access;
    // Software writes zero to clear the flag, or one to raise it by hand.
    wire flag_write = wr_lane0 && wr_idx == `OFS_PERIPHERAL_IRQ_FLAGS_TWO;
    wire [7:0] port_levels = port_f_pin_in & ~port_f_analog;
    // The flag sets whatever the enables say; only the request is gated.
    wire irq_enabled = peripheral_irq_enables_two[`BIT_CMP_CHANGE] &&
        interrupt_control[`BIT_PERIPHERAL_IRQ_ENABLE] &&
        interrupt_control[`BIT_GLOBAL_IRQ_ENABLE];

    // Read data mux.
    reg [7:0] rd_byte;
    reg rd_ok;
    always @* begin
        rd_ok = 1'b1;
        if (rd_idx == `OFS_COMPARATOR_CONTROL) begin
            rd_byte = comparator_control;
        end else if (rd_idx == `OFS_INTERRUPT_CONTROL) begin
            rd_byte = interrupt_control;
        end else if (rd_idx == `OFS_PERIPHERAL_IRQ_FLAGS_TWO) begin
            rd_byte = peripheral_irq_flags_two;
        end else if (rd_idx == `OFS_PERIPHERAL_IRQ_ENABLES_TWO) begin
            rd_byte = peripheral_irq_enables_two;
        end else if (rd_idx == `OFS_PERIPHERAL_IRQ_PRIORITIES_TWO) begin
            rd_byte = peripheral_irq_priorities_two;
        end else if (rd_idx == `OFS_PORT_F_PIN_LEVELS) begin
            rd_byte = port_levels;
        end else if (rd_idx == `OFS_PORT_F_DIRECTION) begin
            rd_byte = port_f_direction;
        end else if (rd_idx == `OFS_PORT_F_LATCH) begin
            rd_byte = port_f_latch;
        end else begin
            rd_byte = 8'h00;
            rd_ok = 1'b0;
        end
    end

    // Synchronisers and capture of the outputs.
    always @(posedge aclk) begin
        if (!aresetn) begin
            one_sync <= 2'h0;
            two_sync <= 2'h0;
            captured <= 2'h0;
        end else begin
            one_sync <= {one_sync[0], cmp_one_raw};
            two_sync <= {two_sync[0], cmp_two_raw};
            if (ctl_access) begin
                captured <= results;
            end
        end
    end

    // AXI4-Lite write channel: address and data accepted in either order.
    // Ready pulses while idle; a master simply holds valid until it is taken.
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= {ADDR_WIDTH{1'b0}};
            w_data <= 32'h0;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready <= !w_held && !s_axi_wready && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wr_idx <= `OFS_PORT_F_LATCH && aw_addr[5:2] < 4'h8) ?
                    `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // AXI4-Lite read channel: one-cycle turnaround after address acceptance.
    // Only one read at a time: arready stays low while the data waits.
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (do_read) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {24'h0, rd_byte};
                s_axi_rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Register file. Sleep has no effect here, so contents survive wake-up.
    always @(posedge aclk) begin
        if (!aresetn) begin
            cmp_two_invert <= CTL_RESET[`BIT_CMP_TWO_INVERT];
            cmp_one_invert <= CTL_RESET[`BIT_CMP_ONE_INVERT];
            inverting_input_switch <= CTL_RESET[`BIT_INPUT_SWITCH];
            mode <= CTL_RESET[2:0];
            interrupt_control <= `RST_INTERRUPT_CONTROL;
            peripheral_irq_flags_two <= `RST_FLAGS_TWO;
            peripheral_irq_enables_two <= `RST_ENABLES_TWO;
            peripheral_irq_priorities_two <= `RST_PRIORITIES_TWO;
            port_f_direction <= `RST_PORT_F_DIRECTION;
            port_f_latch <= `RST_PORT_F_LATCH;
        end else begin
            if (wr_lane0) begin
                if (wr_idx == `OFS_COMPARATOR_CONTROL) begin
                    cmp_two_invert <= w_data[`BIT_CMP_TWO_INVERT];
                    cmp_one_invert <= w_data[`BIT_CMP_ONE_INVERT];
                    inverting_input_switch <= w_data[`BIT_INPUT_SWITCH];
                    mode <= w_data[2:0];
                end else if (wr_idx == `OFS_INTERRUPT_CONTROL) begin
                    interrupt_control <= w_data[7:0];
                end else if (wr_idx == `OFS_PERIPHERAL_IRQ_ENABLES_TWO) begin
                    peripheral_irq_enables_two <= w_data[7:0] & `IMPL_MASK_TWO;
                end else if (wr_idx == `OFS_PERIPHERAL_IRQ_PRIORITIES_TWO) begin
                    peripheral_irq_priorities_two <= w_data[7:0] & `IMPL_MASK_TWO;
                end else if (wr_idx == `OFS_PORT_F_DIRECTION) begin
                    port_f_direction <= w_data[7:0];
                end else if (wr_idx == `OFS_PORT_F_LATCH) begin
                    port_f_latch <= w_data[7:0];
                end
            end
            // Hardware set wins over a software clear in the same cycle.
            if (flag_write) begin
                peripheral_irq_flags_two <= w_data[7:0] & `IMPL_MASK_TWO;
            end
            if (flag_event) begin
                peripheral_irq_flags_two[`BIT_CMP_CHANGE] <= 1'b1;
            end
        end
    end

    // Pin, analog steering and interrupt outputs, all registered.
    always @(posedge aclk) begin
        if (!aresetn) begin
            port_f_pin_out <= 8'h00;
            port_f_pin_oe <= 8'h00;
            port_f_analog <= 8'h7e;
            cmp_one_power <= 1'b0;
            cmp_two_power <= 1'b0;
            cmp_mode_field <= `MODE_RESET;
            internal_ref_to_noninverting <= 1'b0;
            cmp_one_inv_sel_line_five <= 1'b0;
            cmp_two_inv_sel_line_three <= 1'b0;
            cmp_irq <= 1'b0;
            cmp_irq_high_priority <= 1'b0;
            wake_request <= 1'b0;
        end else begin
            cmp_mode_field <= mode;
            cmp_one_power <= powers_on(mode);
            cmp_two_power <= powers_on(mode);
            internal_ref_to_noninverting <= uses_internal_ref(mode);
            cmp_one_inv_sel_line_five <= uses_internal_ref(mode) &&
                inverting_input_switch;
            cmp_two_inv_sel_line_three <= uses_internal_ref(mode) &&
                inverting_input_switch;
            port_f_analog <= analog_pins(mode);
            // Routed pins carry the raw, unsynchronised result with inversion.
            if (routes_outputs(mode)) begin
                port_f_pin_out <= {port_f_latch[7:3], routed_two, routed_one,
                    port_f_latch[0]};
            end else begin
                port_f_pin_out <= port_f_latch;
            end
            port_f_pin_oe <= ~port_f_direction & ~analog_pins(mode);
            cmp_irq <= peripheral_irq_flags_two[`BIT_CMP_CHANGE] && irq_enabled;
            cmp_irq_high_priority <= peripheral_irq_priorities_two[`BIT_CMP_CHANGE];
            wake_request <= sleeping && peripheral_irq_flags_two[`BIT_CMP_CHANGE] &&
                peripheral_irq_enables_two[`BIT_CMP_CHANGE];
        end
    end

endmodule
`default_nettype wire

// *** cmp_consts.vh ***
/*
 * Register offsets, field positions, reset values and mode codes for the
 * dual comparator control block.
 * Assumes a 32-bit AXI4-Lite register bus with one register per aligned word.
 */
`ifndef CMP_CONSTS_VH
`define CMP_CONSTS_VH

`define OFS_COMPARATOR_CONTROL 4'h0
`define OFS_INTERRUPT_CONTROL 4'h1
`define OFS_PERIPHERAL_IRQ_FLAGS_TWO 4'h2
`define OFS_PERIPHERAL_IRQ_ENABLES_TWO 4'h3
`define OFS_PERIPHERAL_IRQ_PRIORITIES_TWO 4'h4
`define OFS_PORT_F_PIN_LEVELS 4'h5
`define OFS_PORT_F_DIRECTION 4'h6
`define OFS_PORT_F_LATCH 4'h7

`define BIT_CMP_TWO_RESULT 7
`define BIT_CMP_ONE_RESULT 6
`define BIT_CMP_TWO_INVERT 5
`define BIT_CMP_ONE_INVERT 4
`define BIT_INPUT_SWITCH 3
`define BIT_CMP_CHANGE 6
`define BIT_GLOBAL_IRQ_ENABLE 7
`define BIT_PERIPHERAL_IRQ_ENABLE 6

`define RST_COMPARATOR_CONTROL 8'h00
`define RST_INTERRUPT_CONTROL 8'h00
`define RST_FLAGS_TWO 8'h00
`define RST_ENABLES_TWO 8'h00
`define RST_PRIORITIES_TWO 8'h4f
`define RST_PORT_F_DIRECTION 8'hff
`define RST_PORT_F_LATCH 8'h00
`define IMPL_MASK_TWO 8'h4f

`define MODE_RESET 3'h0
`define MODE_INTERNAL_REF 3'h6
`define MODE_OFF 3'h7

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// *** cmp_checker.sv ***
/* Port assertions for the dual comparator control block.
   Assumes it is bound into dual_comparator_control, clock aclk. */
`timescale 1ns/1ns
`default_nettype none
module cmp_checker #(
    parameter ADDR_WIDTH = 6
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic sleeping,
    input wire logic wake_request,
    input wire logic cmp_one_power,
    input wire logic cmp_two_power,
    input wire logic [2:0] cmp_mode_field,
    input wire logic internal_ref_to_noninverting,
    input wire logic cmp_one_inv_sel_line_five,
    input wire logic cmp_two_inv_sel_line_three,
    input wire logic [7:0] port_f_pin_oe,
    input wire logic [7:0] port_f_analog
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_ar_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_power_mode: assert property (cmp_one_power == cmp_two_power &&
        cmp_one_power == (cmp_mode_field != 3'h0 && cmp_mode_field != 3'h7))
        else $error("power does not follow mode");
    a_ref_mode: assert property (internal_ref_to_noninverting == (cmp_mode_field == 3'h6))
        else $error("reference select wrong");
    a_switch_mode: assert property (cmp_one_inv_sel_line_five == cmp_two_inv_sel_line_three
        && (!cmp_one_inv_sel_line_five || cmp_mode_field == 3'h6))
        else $error("input switch outside its mode");
    a_wake_sleep: assert property (wake_request |-> $past(sleeping))
        else $error("wake without sleep");
    a_oe_analog: assert property ((port_f_pin_oe & port_f_analog) == 8'h00)
        else $error("analog pin driven");
    a_reset_state: assert property (disable iff (1'b0) !aresetn |=>
        cmp_mode_field == 3'h0 && !cmp_one_power && port_f_analog == 8'h7e)
        else $error("reset state wrong");
    a_read_answer: assert property (s_ar_taken |=> s_axi_rvalid)
        else $error("read answer late");
    a_unmapped_read: assert property (s_ar_taken ##0 s_axi_araddr[ADDR_WIDTH-1] |=>
        s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
endmodule
bind dual_comparator_control cmp_checker #(.ADDR_WIDTH(ADDR_WIDTH)) chk_u (.aclk, .aresetn,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rdata,
    .s_axi_rresp, .sleeping, .wake_request, .cmp_one_power, .cmp_two_power,
    .cmp_mode_field, .internal_ref_to_noninverting, .cmp_one_inv_sel_line_five,
    .cmp_two_inv_sel_line_three, .port_f_pin_oe, .port_f_analog);
`default_nettype wire

// *** cmp_analog_side.sv ***
/* Behavioural analog side: two comparators and the internal reference.
   Assumes levels are driven by the bench as plain 8-bit magnitudes. */
`timescale 1ns/1ns
`default_nettype none
module cmp_analog_side (
    input wire logic cmp_one_power,
    input wire logic cmp_two_power,
    input wire logic internal_ref_to_noninverting,
    input wire logic cmp_one_inv_sel_line_five,
    input wire logic cmp_two_inv_sel_line_three,
    input wire logic [7:0] ref_level,
    input wire logic [7:0] one_plus,
    input wire logic [7:0] one_minus,
    input wire logic [7:0] two_plus,
    input wire logic [7:0] two_minus,
    input wire logic [7:0] alt_minus,
    output logic cmp_one_raw,
    output logic cmp_two_raw
);
    // Equal levels give low; real parts are uncertain there, so tests avoid them.
    wire [7:0] one_p = internal_ref_to_noninverting ? ref_level : one_plus;
    wire [7:0] two_p = internal_ref_to_noninverting ? ref_level : two_plus;
    wire [7:0] one_m = cmp_one_inv_sel_line_five ? alt_minus : one_minus;
    wire [7:0] two_m = cmp_two_inv_sel_line_three ? alt_minus : two_minus;
    assign cmp_one_raw = cmp_one_power && (one_p > one_m);
    assign cmp_two_raw = cmp_two_power && (two_p > two_m);
endmodule
`default_nettype wire

// *** tb_top.sv ***
/* Self-checking bench for the dual comparator control block.
   Assumes the AXI4-Lite slave and analog model described alongside. */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_rready, sleeping;
    logic [5:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata;
    logic [3:0] s_axi_wstrb;
    logic [7:0] port_f_pin_in, ref_level, one_plus, one_minus, two_plus, two_minus, alt_minus;
    logic [1:0] last_resp;
    wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire logic [1:0] s_axi_bresp, s_axi_rresp;
    wire logic [31:0] s_axi_rdata;
    wire logic cmp_one_raw, cmp_two_raw, cmp_one_power, cmp_two_power, cmp_irq, wake_request;
    wire logic internal_ref_to_noninverting, cmp_one_inv_sel_line_five;
    wire logic cmp_two_inv_sel_line_three, cmp_irq_high_priority;
    wire logic [7:0] port_f_pin_out, port_f_pin_oe, port_f_analog;
    wire logic [2:0] cmp_mode_field;
    int err_total = 0;
    int checks_done = 0;
    dual_comparator_control dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .cmp_one_raw, .cmp_two_raw, .port_f_pin_in, .sleeping, .port_f_pin_out,
        .port_f_pin_oe, .port_f_analog, .cmp_one_power, .cmp_two_power, .cmp_mode_field,
        .internal_ref_to_noninverting, .cmp_one_inv_sel_line_five,
        .cmp_two_inv_sel_line_three, .cmp_irq, .cmp_irq_high_priority, .wake_request);
    cmp_analog_side model_u (.cmp_one_power, .cmp_two_power, .internal_ref_to_noninverting,
        .cmp_one_inv_sel_line_five, .cmp_two_inv_sel_line_three, .ref_level, .one_plus,
        .one_minus, .two_plus, .two_minus, .alt_minus, .cmp_one_raw, .cmp_two_raw);
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done = checks_done + 1;
        if (got !== exp) begin
            err_total = err_total + 1;
            $display("FAIL at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Register index in, byte address out: each register owns one aligned word.
    task automatic wr(input logic [3:0] idx, input logic [7:0] d);
        @(posedge aclk);
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        last_resp = s_axi_bresp;
    endtask
    task automatic rd(input logic [3:0] idx, input logic [31:0] exp);
        @(posedge aclk);
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        last_resp = s_axi_rresp;
        chk(s_axi_rdata, exp);
    endtask
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    initial begin
        #400000;
        err_total = err_total + 1;
        report_and_stop;
    end
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 5'h0;
        {s_axi_rready, sleeping, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 0;
        s_axi_wstrb = 4'hf;
        port_f_pin_in = 8'hff;
        {ref_level, alt_minus} = {8'd150, 8'd200};
        {one_plus, one_minus, two_plus, two_minus} = {8'd200, 8'd100, 8'd50, 8'd100};
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        rd(4'h0, 32'h00);
        rd(4'h2, 32'h00);
        rd(4'h6, 32'hff);
        rd(4'h5, 32'h81);
        rd(4'h4, 32'h4f);
        rd(4'h8, 32'h00);
        chk(last_resp, 2'h2);
        wr(4'h8, 8'h00);
        chk(last_resp, 2'h2);
        chk(port_f_analog, 8'h7e);
        $display("test reset done");
        wr(4'h0, 8'h3f);
        chk(last_resp, 2'h0);
        repeat (6) @(posedge aclk);
        chk(cmp_mode_field, 3'h7);
        rd(4'h0, 32'hff);
        chk(cmp_one_power, 1'b0);
        rd(4'h5, 32'hff);
        wr(4'h6, 8'h00);
        repeat (3) @(posedge aclk);
        chk(port_f_pin_oe, 8'hff);
        wr(4'h0, 8'hc2);
        repeat (6) @(posedge aclk);
        rd(4'h0, 32'h42);
        wr(4'h0, 8'h32);
        repeat (6) @(posedge aclk);
        rd(4'h0, 32'hb2);
        $display("test output done");
        wr(4'h0, 8'h0e);
        repeat (6) @(posedge aclk);
        chk({internal_ref_to_noninverting, cmp_one_inv_sel_line_five}, 2'h3);
        rd(4'h0, 32'h0e);
        wr(4'h0, 8'h06);
        repeat (6) @(posedge aclk);
        chk(cmp_two_inv_sel_line_three, 1'b0);
        rd(4'h0, 32'hc6);
        $display("test reference done");
        wr(4'h0, 8'h02);
        repeat (6) @(posedge aclk);
        rd(4'h0, 32'h42);
        wr(4'h2, 8'h00);
        rd(4'h2, 32'h00);
        one_plus <= 8'd0;
        repeat (6) @(posedge aclk);
        rd(4'h2, 32'h40);
        wr(4'h2, 8'h00);
        rd(4'h2, 32'h40);
        rd(4'h0, 32'h02);
        wr(4'h2, 8'h00);
        rd(4'h2, 32'h00);
        wr(4'h2, 8'h40);
        rd(4'h2, 32'h40);
        for (int i = 0; i < 8; i++) begin
            wr(4'h1, {i[2], i[1], 6'h0});
            wr(4'h3, {1'b0, i[0], 6'h0});
            repeat (2) @(posedge aclk);
            chk(cmp_irq, &i[2:0]);
        end
        wr(4'h4, 8'h00);
        repeat (2) @(posedge aclk);
        chk(cmp_irq_high_priority, 1'b0);
        wr(4'h4, 8'h40);
        repeat (2) @(posedge aclk);
        chk(cmp_irq_high_priority, 1'b1);
        $display("test flag done");
        sleeping <= 1'b1;
        repeat (3) @(posedge aclk);
        chk(wake_request, 1'b1);
        rd(4'h0, 32'h02);
        wr(4'h3, 8'h00);
        repeat (2) @(posedge aclk);
        chk(wake_request, 1'b0);
        sleeping <= 1'b0;
        one_plus <= 8'd200;
        wr(4'h0, 8'h03);
        repeat (6) @(posedge aclk);
        chk(port_f_pin_out[2:1], 2'h1);
        chk(port_f_pin_oe[2:1], 2'h3);
        wr(4'h0, 8'h13);
        repeat (6) @(posedge aclk);
        chk(port_f_pin_out[2:1], 2'h0);
        wr(4'h6, 8'h02);
        repeat (2) @(posedge aclk);
        chk(port_f_pin_oe[2:1], 2'h2);
        wr(4'h0, 8'h25);
        repeat (6) @(posedge aclk);
        chk(port_f_pin_out[2:1], 2'h3);
        wr(4'h0, 8'h04);
        repeat (6) @(posedge aclk);
        chk({port_f_analog, port_f_pin_out[2:1]}, 10'h1e0);
        $display("test sleep and routing done");
        report_and_stop;
    end
endmodule
`default_nettype wire
